// [bench/pdd_led_boost_model.sv]
// LED strings and boost output stage model driving the comparator inputs
`timescale 1ns/100ps
module pdd_led_boost_model
   import pdd_pkg::*;
(
   input  wire logic           core_clk,
   input  wire logic [NCH-1:0] led_sink_pin,
   input  wire logic           boost_sw_pulse,
   input  wire logic           reg_arm,
   input  wire logic           ovp_arm,
   input  wire logic           sync_on,
   output logic                led_in_regulation,
   output logic                vout_near_ovp,
   output logic                hyst_upper_level,
   output logic                hyst_lower_level,
   output logic                freq_set_sync_pin
);
   int vout = 0;
   int ph   = 0;
   // Output charge: one step per switching pulse, drained hard while strings conduct
   always @(posedge core_clk) begin
      ph <= ph + 1;
      if (boost_sw_pulse && vout < 40) vout <= vout + 1;
      else if (|led_sink_pin && ph % 4 == 0 && vout > 0) vout <= vout - 1;
   end
   // Comparators on the modelled output level
   assign hyst_upper_level  = vout >= 20;
   assign hyst_lower_level  = vout < 16;
   assign vout_near_ovp     = ovp_arm && vout >= 36;
   assign led_in_regulation = reg_arm && (|led_sink_pin) && vout >= 16;
   // Sync clock only while requested, idles low so no stray edges reach the block
   always @(posedge core_clk) freq_set_sync_pin <= sync_on && (ph % 40 >= 20);
endmodule

// [bench/tb_polyphase_dimming_dither_ctrl.sv]
// Self-checking testbench for the polyphase dimming and dither controller
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
`define WAIT_UNTIL(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(posedge core_clk); #1; n++; end \
   `CHK(n < (lim), 1'b1) end
module tb_polyphase_dimming_dither_ctrl import pdd_pkg::*;;
   localparam int SS_LEN = 30000;
   logic             core_clk = 1'b0;
   logic             resetn = 1'b0;
   logic             clk_en = 1'b1;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic             ext_sync_active = 1'b0;
   logic             reg_arm = 1'b0;
   logic             ovp_arm = 1'b0;
   logic             sync_on = 1'b0;
   logic [7:0]       reg_addr = 8'h00;
   logic [7:0]       reg_wdata = 8'h00;
   logic [7:0]       reg_rdata;
   logic [CH_W-1:0]  dominant_sel = '0;
   logic [NCH-1:0]   led_sink_pin;
   logic [NCH-1:0]   prev;
   logic             boost_switch_en, boost_sw_pulse, dither_high, soft_start_active;
   logic             led_in_regulation, vout_near_ovp, hyst_upper_level, hyst_lower_level, freq_set_sync_pin;
   int               num_errors = 0;
   int               num_checks = 0;
   int               n;
   int               rise[NCH];
   int               wid[NCH];
   int               iv[200];

   always #5 core_clk = ~core_clk;

   pdd_ctrl #(.SOFT_START_LEN(SS_LEN)) u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .freq_set_sync_pin(freq_set_sync_pin), .ext_sync_active(ext_sync_active),
      .led_in_regulation(led_in_regulation), .vout_near_ovp(vout_near_ovp),
      .hyst_upper_level(hyst_upper_level), .hyst_lower_level(hyst_lower_level),
      .dominant_sel(dominant_sel), .led_sink_pin(led_sink_pin), .boost_switch_en(boost_switch_en),
      .boost_sw_pulse(boost_sw_pulse), .dither_high(dither_high), .soft_start_active(soft_start_active));

   pdd_led_boost_model u_model (.core_clk(core_clk), .led_sink_pin(led_sink_pin),
      .boost_sw_pulse(boost_sw_pulse), .reg_arm(reg_arm), .ovp_arm(ovp_arm), .sync_on(sync_on),
      .led_in_regulation(led_in_regulation), .vout_near_ovp(vout_near_ovp),
      .hyst_upper_level(hyst_upper_level), .hyst_lower_level(hyst_lower_level),
      .freq_set_sync_pin(freq_set_sync_pin));

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic do_reset;
      resetn = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      resetn = 1'b1;
   endtask

   // Register cycles: strobe held one edge, read data taken after that edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // Cycles from now to the next switching pulse, bounded against a stuck clock
   task automatic next_pulse(output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         #1;
         c++;
      end while (boost_sw_pulse !== 1'b1 && c < 200);
   endtask

   // Settle one period, then log first rise and width of each sink over three
   task automatic observe;
      repeat (300) @(posedge core_clk);
      #1;
      prev = led_sink_pin;
      rise = '{default: -1};
      wid = '{default: -1};
      for (int t = 0; t < 900; t++) begin
         @(posedge core_clk);
         #1;
         for (int k = 0; k < NCH; k++) begin
            if (led_sink_pin[k] && !prev[k] && rise[k] < 0) rise[k] = t;
            if (!led_sink_pin[k] && prev[k] && rise[k] >= 0 && wid[k] < 0) wid[k] = t - rise[k];
         end
         prev = led_sink_pin;
      end
   endtask

   function automatic int rel(int k);
      return ((rise[k] - rise[0]) % 300 + 300) % 300;
   endfunction

   task automatic t_regs;
      logic [7:0] v;
      logic [7:0] ta[5] = '{ADDR_CHAN_EN, ADDR_DITHER, ADDR_GRP_LO, ADDR_ON_LAST, 8'h07};
      logic [7:0] tw[5] = '{8'ha5, 8'hff, 8'hff, 8'h5a, 8'h33};
      logic [7:0] te[5] = '{8'ha5, 8'h03, 8'hfe, 8'h5a, 8'h00};
      // Status after reset: ramp running, boost allowed, dither level low
      rd(ADDR_STATUS, v);
      `CHK(v, 8'h06)
      for (int i = 0; i < 5; i++) begin
         rd(ta[i], v);
         `CHK(v, REG_RESET)
         wr(ta[i], tw[i]);
         rd(ta[i], v);
         `CHK(v, te[i])
      end
      $display("test regs done");
   endtask

   task automatic t_dither;
      int dl[4] = '{0, 2, 5, 7};
      int nom, cnt, par, pn;
      logic lv;
      nom = int'(SW_NOM_CYCLES);
      for (int d = 0; d < 4; d++) begin
         wr(ADDR_DITHER, 8'(d));
         repeat (3) next_pulse(pn);
         cnt = (d == 2) ? 186 : 24;
         par = -1;
         for (int i = 0; i < cnt; i++) begin
            // Level shown at a pulse governs the cycle that follows it
            lv = dither_high;
            next_pulse(iv[i]);
            `CHK(iv[i], lv ? nom - dl[d] : nom + dl[d])
            `CHK(iv[i] == nom - dl[d] || iv[i] == nom + dl[d], 1'b1)
            if (i > 0 && iv[i] != iv[i-1]) begin
               if (par < 0) par = i % 2;
               `CHK(i % 2, par)
            end
         end
         if (d == 2) begin
            `CHK(par >= 0, 1'b1)
            for (int i = 0; i < 92; i++) `CHK(iv[i], iv[i+92])
         end
      end
      // External sync: pulses follow the pin and the level never moves
      ext_sync_active = 1'b1;
      sync_on = 1'b1;
      repeat (3) next_pulse(pn);
      for (int i = 0; i < 8; i++) begin
         next_pulse(pn);
         `CHK(pn, 40)
         `CHK(dither_high, 1'b0)
      end
      ext_sync_active = 1'b0;
      sync_on = 1'b0;
      $display("test dither done");
   endtask

   task automatic t_slots;
      int ex;
      wr(ADDR_PERIOD_LO, 8'h01);
      wr(ADDR_PERIOD_HI, 8'h00);
      wr(ADDR_GRP_LO, 8'h00);
      for (int k = 0; k < NCH; k++) begin
         wr(ADDR_ON_FIRST + 8'(2 * k), (k == 0) ? 8'h03 : 8'(8 + k));
         wr(ADDR_ON_FIRST + 8'(2 * k + 1), 8'h00);
      end
      wr(ADDR_CHAN_EN, 8'hff);
      observe;
      for (int k = 0; k < NCH; k++) begin
         ex = ((k == 0) ? int'(MIN_ON_TICKS) : 8 + k) * TICK_CYCLES;
         `CHK(rel(k), (k * 2 * PER_UNIT_TICKS / NCH) * TICK_CYCLES)
         `CHK(wid[k] >= ex - TICK_CYCLES && wid[k] <= ex + TICK_CYCLES, 1'b1)
      end
      // Clock enable low must freeze the sinks mid-period
      clk_en = 1'b0;
      prev = led_sink_pin;
      repeat (40) @(posedge core_clk);
      #1;
      `CHK(led_sink_pin, prev)
      clk_en = 1'b1;
      $display("test slots done");
   endtask

   task automatic t_group;
      wr(ADDR_GRP_LO, 8'h06);
      observe;
      `CHK(wid[0] > 0, 1'b1)
      `CHK(rise[1], rise[0])
      `CHK(rise[2], rise[0])
      `CHK(wid[2], wid[0])
      `CHK(rel(3), 7 * TICK_CYCLES)
      wr(ADDR_CHAN_EN, 8'hfb);
      observe;
      `CHK(rise[2], rise[0])
      `CHK(wid[2] > 0 && wid[2] == wid[0], 1'b1)
      wr(ADDR_CHAN_EN, 8'hfe);
      observe;
      `CHK(rise[1] + rise[2], -2)
      `CHK(prev[2:0], 3'b000)
      `CHK(rise[3] >= 0, 1'b1)
      $display("test group done");
   endtask

   task automatic t_soft;
      do_reset;
      `WAIT_UNTIL(soft_start_active === 1'b0, SS_LEN + 10)
      `CHK(n >= SS_LEN - 2 && n <= SS_LEN + 2, 1'b1)
      ovp_arm = 1'b1;
      do_reset;
      `WAIT_UNTIL(soft_start_active === 1'b0, 10)
      ovp_arm = 1'b0;
      reg_arm = 1'b1;
      do_reset;
      wr(ADDR_PERIOD_LO, 8'h27);
      wr(ADDR_PERIOD_HI, 8'h00);
      wr(ADDR_ON_FIRST + 8'h01, 8'h01);
      wr(ADDR_CHAN_EN, 8'h01);
      `CHK(soft_start_active, 1'b1)
      `WAIT_UNTIL(led_sink_pin[0] === 1'b1, 7000)
      `WAIT_UNTIL(soft_start_active === 1'b0, 4)
      // Output drained while lit; boost must run on until the upper level
      `WAIT_UNTIL(led_sink_pin[0] === 1'b0, 5000)
      `CHK(boost_switch_en, 1'b1)
      repeat (300) @(posedge core_clk);
      #1;
      `CHK(boost_switch_en, 1'b1)
      `CHK(hyst_upper_level, 1'b0)
      `WAIT_UNTIL(boost_switch_en === 1'b0, 2000)
      `CHK(hyst_upper_level, 1'b1)
      $display("test soft start done");
   endtask

   initial begin
      do_reset;
      t_regs;
      t_dither;
      t_slots;
      t_group;
      t_soft;
      test_done;
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(100000 * 10);
      num_errors++;
      test_done;
   end
endmodule

// [hw/pdd_ctrl.sv]
// Polyphase dimming scheduler, soft start and boost enable with register file
//
// Summary of operation
// - External sync clock in use suppresses all switching-frequency dither.
// - Two-bit depth field; nonzero enables dither at 5, 10 or 15 percent (truncated here to 4, 10, 14).
// - Dither level may change only once every two switching cycles.
// - Pseudo-random pattern of 46 entries, two cycles each, repeats in 92.
// - Ungrouped channels each start in their own sequential periodic slot.
// - Each channel has an enable bit and its own on-time setting.
// - Enabled channel turns on at slot start for its own on-time.
// - Grouping bits join adjacent channels so they switch together.
// - Grouped channel uses lower neighbour's slot and on-time; own slot unused.
// - A whole group starts in lowest member's slot with its on-time.
// - Disabled lowest member disables every channel of its group.
// - Disabled non-first member still runs with its group on first on-time.
// - Slot positions stay fixed; on-times may overlap later slots.
// - Per-channel current setting is untouched by grouping.
// - Soft start lasts 100 ms unless ended early.
// - Soft start ends on LED regulation or output at 90 percent of OVERVOLTAGE_THRESHOLD.
// - After dominant channel off, switch to upper level then hold hysteresis.
// - Dimming period is (N+1) times 1.5 us, N 13 bits, writable anytime.
// - On-time is 16 bits in 0.15 us steps, never below 1 us.
`timescale 1ns/100ps
module pdd_ctrl
   import pdd_pkg::*;
#(
   parameter int SOFT_START_LEN = SOFT_START_CYCLES
) (
   input  wire logic            core_clk,
   input  wire logic            resetn,
   input  wire logic            clk_en,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [7:0]      reg_rdata,
   input  wire logic            freq_set_sync_pin,
   input  wire logic            ext_sync_active,
   input  wire logic            led_in_regulation,
   input  wire logic            vout_near_ovp,
   input  wire logic            hyst_upper_level,
   input  wire logic            hyst_lower_level,
   input  wire logic [CH_W-1:0] dominant_sel,
   output logic      [NCH-1:0]  led_sink_pin,
   output logic                 boost_switch_en,
   output logic                 boost_sw_pulse,
   output logic                 dither_high,
   output logic                 soft_start_active
);
   localparam logic [SS_W-1:0]  SS_LAST  = SS_W'(SOFT_START_LEN - 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

   pdd_ctrl_state_t s_q, s_d;

   logic                     tick;
   logic [TCNT_W-1:0]        per_ticks;
   logic [7:0]               on_off;
   logic                     on_hit;
   logic                     sw_pulse;
   logic                     dom_on;
   logic                     run_n;
   logic [NCH-1:0]           grp_bit;
   logic [NCH-1:0][CH_W-1:0] root;
   logic [NCH-1:0][TCNT_W-1:0] slot_pos;
   logic [NCH-1:0][ON_W-1:0] on_src;
   logic [NCH-1:0][ON_W-1:0] on_load;
   logic [NCH-1:0][ON_W-1:0] rem_n;
   logic [NCH-1:0]           en_eff;
   logic [NCH-1:0]           start;
   logic [NCH-1:0]           sink_n;

   // Boost clock source with dither
   pdd_dither u_dither (
      .core_clk          (core_clk),
      .resetn            (resetn),
      .clk_en            (clk_en),
      .dither_depth_sel  (s_q.dither[DEPTH_W-1:0]),
      .ext_sync_active   (ext_sync_active),
      .freq_set_sync_pin (freq_set_sync_pin),
      .sw_pulse          (sw_pulse),
      .dither_high       (dither_high)
   );

   // 0.15 us time base and the dimming period in those ticks
   assign tick = (s_q.pre == PRE_LAST);
   assign per_ticks = TCNT_W'((32'(s_q.period_n) + 32'd1) * PER_UNIT_TICKS);
   assign on_off = reg_addr - ADDR_ON_FIRST;
   assign on_hit = (reg_addr >= ADDR_ON_FIRST) && (reg_addr <= ADDR_ON_LAST);
   assign grp_bit = s_q.grp_lo;

   // Per-channel slot, group root and on-time counter
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // Fixed even slot spacing, independent of grouping
      assign slot_pos[i] = TCNT_W'((32'(per_ticks) * i) >> CH_W);

      // Walk grouping down to the lowest-numbered member
      if (i == 0) begin : g_first
         assign root[i] = '0;
      end else begin : g_rest
         assign root[i] = grp_bit[i] ? root[i-1] : CH_W'(i);
      end

      // Enable follows the group's first member only
      assign en_eff[i] = s_q.chan_en[root[i]];
      assign on_src[i] = s_q.on_time[root[i]];

      // Zero means dark; anything shorter than 1 us is stretched
      always_comb begin
         if (on_src[i] == '0) begin
            on_load[i] = '0;
         end else if (on_src[i] < MIN_ON_TICKS) begin
            on_load[i] = MIN_ON_TICKS;
         end else begin
            on_load[i] = on_src[i];
         end
      end

      assign start[i] = tick && (s_q.tcnt == slot_pos[root[i]]);

      // A new slot reloads even while still on, so long pulses overlap
      always_comb begin
         if (!en_eff[i]) begin
            rem_n[i] = '0;
         end else if (start[i]) begin
            rem_n[i] = on_load[i];
         end else if (tick && (s_q.remain[i] != '0)) begin
            rem_n[i] = s_q.remain[i] - 16'h0001;
         end else begin
            rem_n[i] = s_q.remain[i];
         end
      end

      // Only timing is gated here; sink current stays per channel
      assign sink_n[i] = en_eff[i] && (rem_n[i] != '0);

      a_slot_start: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
         $rose(s_q.sink[i]) |-> $past(start[i])) else $error("sink rose outside its slot");
      a_root_off: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
         $past(!s_q.chan_en[root[i]]) && $stable(s_q.grp_lo) |-> !s_q.sink[i])
         else $error("sink on with group head disabled");
      if (i > 0) begin : g_pair
         a_group_pair: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
            ($past(grp_bit[i]) && grp_bit[i] && $rose(s_q.sink[i-1])) |-> s_q.sink[i])
            else $error("grouped channel not switching with neighbour");
      end
   end

   // Dominant string on, or hysteresis window after it turns off
   assign dom_on = s_q.sink[dominant_sel];

   always_comb begin
      if (dom_on) begin
         run_n = 1'b1;
      end else if (hyst_upper_level) begin
         run_n = 1'b0;
      end else if (hyst_lower_level) begin
         run_n = 1'b1;
      end else begin
         run_n = s_q.hyst_run;
      end
   end

   // Next state of the whole controller
   always_comb begin
      s_d = s_q;

      // Byte writes; unmapped addresses are ignored
      if (reg_wr) begin
         case (reg_addr)
            ADDR_CHAN_EN:   s_d.chan_en = reg_wdata;
            ADDR_PERIOD_LO: s_d.period_n[7:0] = reg_wdata;
            ADDR_PERIOD_HI: s_d.period_n[PER_W-1:8] = reg_wdata[PER_W-9:0];
            ADDR_DITHER:    s_d.dither = {6'h00, reg_wdata[DEPTH_W-1:0]};
            ADDR_GRP_LO:    s_d.grp_lo = {reg_wdata[7:1], 1'b0};
            ADDR_GRP_HI:    s_d.grp_hi = reg_wdata;
            default:        s_d.dither = s_q.dither;
         endcase
         if (on_hit) begin
            if (on_off[0]) begin
               s_d.on_time[on_off[3:1]][15:8] = reg_wdata;
            end else begin
               s_d.on_time[on_off[3:1]][7:0] = reg_wdata;
            end
         end
      end

      // Read data captured one cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CHAN_EN:   s_d.rdata = s_q.chan_en;
            ADDR_PERIOD_LO: s_d.rdata = s_q.period_n[7:0];
            ADDR_PERIOD_HI: s_d.rdata = {3'h0, s_q.period_n[PER_W-1:8]};
            ADDR_STATUS:    s_d.rdata = {5'h00, s_q.ss == PDD_SS_RAMP, s_q.boost_en, dither_high};
            ADDR_DITHER:    s_d.rdata = s_q.dither;
            ADDR_SINK_STAT: s_d.rdata = s_q.sink;
            ADDR_GRP_LO:    s_d.rdata = s_q.grp_lo;
            ADDR_GRP_HI:    s_d.rdata = s_q.grp_hi;
            default:        s_d.rdata = 8'h00;
         endcase
         if (on_hit) begin
            s_d.rdata = on_off[0] ? s_q.on_time[on_off[3:1]][15:8] : s_q.on_time[on_off[3:1]][7:0];
         end
      end

      // Prescaler and period counter; a shortened period wraps at once
      s_d.pre = tick ? '0 : s_q.pre + 5'h01;
      if (tick || (s_q.tcnt >= per_ticks)) begin
         if (s_q.tcnt >= per_ticks - 17'h00001) begin
            s_d.tcnt = '0;
         end else begin
            s_d.tcnt = s_q.tcnt + 17'h00001;
         end
      end

      s_d.remain = rem_n;
      s_d.sink = sink_n;

      // Soft start: fixed ramp, cut short by either comparator
      case (s_q.ss)
         PDD_SS_RAMP: begin
            if (led_in_regulation || vout_near_ovp) begin
               s_d.ss = PDD_SS_DONE;
            end else if (s_q.ss_cnt == SS_LAST) begin
               s_d.ss = PDD_SS_DONE;
            end else begin
               s_d.ss_cnt = s_q.ss_cnt + 24'h000001;
            end
         end
         PDD_SS_DONE: begin
            s_d.ss_cnt = s_q.ss_cnt;
         end
         default: begin
            s_d.ss = PDD_SS_DONE;
         end
      endcase

      // Boost switches through soft start, then on regulation demand
      s_d.hyst_run = run_n;
      s_d.boost_en = (s_q.ss == PDD_SS_RAMP) || dom_on || run_n;
      s_d.pulse = sw_pulse && s_d.boost_en;
   end

   // Single state register; clock enable freezes everything
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.period_n <= PERIOD_RESET;
         s_q.chan_en <= REG_RESET;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign led_sink_pin = s_q.sink;
   assign boost_switch_en = s_q.boost_en;
   assign boost_sw_pulse = s_q.pulse;
   assign soft_start_active = (s_q.ss == PDD_SS_RAMP);

   sequence seq_dom_release;
      !dom_on && hyst_upper_level && !soft_start_active;
   endsequence

   sequence seq_ss_natural_end;
      soft_start_active && !led_in_regulation && !vout_near_ovp ##1 !soft_start_active;
   endsequence

   a_period_wrap: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      $stable(s_q.period_n) |-> (s_q.tcnt < per_ticks)) else $error("phase counter past period");
   a_ss_early: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      (soft_start_active && (led_in_regulation || vout_near_ovp)) |=> !soft_start_active)
      else $error("soft start not ended by comparator");
   a_ss_length: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      seq_ss_natural_end |-> $past(s_q.ss_cnt) == SS_LAST) else $error("soft start length wrong");
   a_hyst_stop: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      seq_dom_release |=> !boost_switch_en) else $error("boost still switching above upper level");
   a_dom_boost: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      (dom_on ##1 dom_on) |-> boost_switch_en ##1 boost_switch_en)
      else $error("boost off while dominant string lit");
   a_min_on: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      (start[0] && en_eff[0] && on_src[0] != '0) |=> (s_q.remain[0] >= MIN_ON_TICKS))
      else $error("on-time below 1 us");
endmodule

// [hw/pdd_dither.sv]
// Boost switching clock generator with pseudo-random frequency dither
`timescale 1ns/100ps
module pdd_dither
   import pdd_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire logic               clk_en,
   input  wire logic [DEPTH_W-1:0] dither_depth_sel,
   input  wire logic               ext_sync_active,
   input  wire logic               freq_set_sync_pin,
   output logic                    sw_pulse,
   output logic                    dither_high
);
   pdd_dith_state_t s_q, s_d;
   logic            active;
   logic            cyc_end;
   logic [SW_W-1:0] delta;
   logic            lvl_n;

   // Dither only on the internal oscillator with a non-zero depth
   assign active = (dither_depth_sel != '0) && !ext_sync_active;
   // Codes 1..3 give 2, 5, 7 cycles of 50 (4, 10, 14 percent); shift kept symmetric about nominal
   assign delta = SW_W'((int'(SW_NOM_CYCLES) * DITHER_PCT_STEP * int'(dither_depth_sel)) / 100);
   assign cyc_end = (s_q.cnt >= s_q.per - 8'h01);
   assign lvl_n = DITHER_PATTERN[s_q.idx];

   // Next state: period counter, pair parity and pattern walk
   always_comb begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      s_d.sync_prev = freq_set_sync_pin;
      if (ext_sync_active) begin
         // External clock: one pulse per rising edge, never dithered
         s_d.pulse = freq_set_sync_pin && !s_q.sync_prev;
         s_d.cnt = '0;
         s_d.level = 1'b0;
      end else if (cyc_end) begin
         s_d.cnt = '0;
         s_d.pulse = 1'b1;
         s_d.par = !s_q.par;
         // Level may only move at the end of a pair of cycles
         if (s_q.par && active) begin
            s_d.level = lvl_n;
            s_d.idx = (s_q.idx == PATTERN_LAST) ? 6'h00 : s_q.idx + 6'h01;
         end
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
      if (!active) begin
         s_d.level = 1'b0;
         s_d.idx = '0;
      end
      // High frequency means a shorter period
      if (!active) begin
         s_d.per = SW_NOM_CYCLES;
      end else if (s_d.level) begin
         s_d.per = SW_NOM_CYCLES - delta;
      end else begin
         s_d.per = SW_NOM_CYCLES + delta;
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.per <= SW_NOM_CYCLES;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign sw_pulse = s_q.pulse;
   assign dither_high = s_q.level;

   sequence seq_pair_end;
      cyc_end && s_q.par && !ext_sync_active;
   endsequence

   a_sync_no_dither: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      ext_sync_active |=> !dither_high) else $error("dither active in sync mode");
   a_depth_nominal: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      (dither_depth_sel == '0) |=> (s_q.per == SW_NOM_CYCLES)) else $error("period off nominal");
   a_level_pairs: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      ($past(active) && active && $changed(s_q.level)) |-> $past(cyc_end && s_q.par))
      else $error("level moved mid pair");
   a_pattern_step: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
      (seq_pair_end ##0 active && s_q.idx == PATTERN_LAST) |=> (s_q.idx == 6'h00))
      else $error("pattern did not wrap at 46");
endmodule

// [hw/pdd_pkg.sv]
// Shared constants and types for the polyphase dimming and dither controller
package pdd_pkg;
   // Channel count and register addresses
   localparam int NCH  = 8;
   localparam int CH_W = 3;
   localparam logic [7:0] ADDR_CHAN_EN   = 8'h01;
   localparam logic [7:0] ADDR_PERIOD_LO = 8'h02;
   localparam logic [7:0] ADDR_PERIOD_HI = 8'h03;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_DITHER    = 8'h05;
   localparam logic [7:0] ADDR_SINK_STAT = 8'h06;
   localparam logic [7:0] ADDR_GRP_LO    = 8'h08;
   localparam logic [7:0] ADDR_GRP_HI    = 8'h09;
   localparam logic [7:0] ADDR_ON_FIRST  = 8'h10;
   localparam logic [7:0] ADDR_ON_LAST   = 8'h1f;
   // Field layout
   localparam int PER_W   = 13;
   localparam int ON_W    = 16;
   localparam int TCNT_W  = 17;
   localparam int PRE_W   = 5;
   localparam int SS_W    = 24;
   localparam int DEPTH_W = 2;
   localparam int ST_SS   = 2;
   localparam int ST_BOOST = 1;
   localparam int ST_DITH = 0;
   localparam logic [PER_W-1:0] PERIOD_RESET = 13'h0d05;
   localparam logic [7:0]       REG_RESET    = 8'h00;
   // Timing, all derived from the 10 ns core clock
   localparam int CLK_PS      = 10000;
   localparam int TICK_PS     = 150000;
   localparam int PER_UNIT_PS = 1500000;
   localparam int MIN_ON_PS   = 1000000;
   localparam int SOFT_START_MS = 100;
   localparam int TICK_CYCLES = TICK_PS / CLK_PS;
   localparam int PER_UNIT_TICKS = PER_UNIT_PS / TICK_PS;
   localparam logic [ON_W-1:0] MIN_ON_TICKS = ON_W'((MIN_ON_PS + TICK_PS - 1) / TICK_PS);
   localparam int SOFT_START_CYCLES = SOFT_START_MS * (1000000000 / CLK_PS);
   // Boost clock dither
   localparam int SW_W = 8;
   localparam logic [SW_W-1:0] SW_NOM_CYCLES = 8'h32;
   localparam int DITHER_PCT_STEP = 5;
   localparam int PATTERN_LEN = 46;
   localparam logic [5:0] PATTERN_LAST = 6'(PATTERN_LEN - 1);
   localparam logic [PATTERN_LEN-1:0] DITHER_PATTERN = 46'h1a7_3c95_e2d6;

   typedef enum logic {PDD_SS_RAMP = 1'b0, PDD_SS_DONE = 1'b1} pdd_ss_t;

   typedef struct packed {
      logic [7:0]                chan_en;
      logic [7:0]                dither;
      logic [7:0]                grp_lo;
      logic [7:0]                grp_hi;
      logic [PER_W-1:0]          period_n;
      logic [NCH-1:0][ON_W-1:0]  on_time;
      logic [7:0]                rdata;
      logic [PRE_W-1:0]          pre;
      logic [TCNT_W-1:0]         tcnt;
      logic [NCH-1:0][ON_W-1:0]  remain;
      logic [NCH-1:0]            sink;
      logic                      hyst_run;
      logic                      boost_en;
      logic                      pulse;
      pdd_ss_t                   ss;
      logic [SS_W-1:0]           ss_cnt;
   } pdd_ctrl_state_t;

   typedef struct packed {
      logic [SW_W-1:0] cnt;
      logic [SW_W-1:0] per;
      logic            par;
      logic [5:0]      idx;
      logic            level;
      logic            sync_prev;
      logic            pulse;
   } pdd_dith_state_t;
endpackage
